// ==== nfsp_cyc.sv ====
// One asynchronous flash bus cycle, read or write, with pin synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "nfsp_regs.svh"
module nfsp_cyc
   import nfsp_pkg::*;
#(
   parameter int P_AW = 23
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_en,
   // Cycle request
   input wire logic i_go,
   input wire logic i_write,
   input wire logic [P_AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic o_done,
   output logic [7:0] o_rdata,
   // Flash pins
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [P_AW-1:0] o_addr,
   output logic [7:0] o_dq,
   output logic o_dq_oe,
   input wire logic [7:0] i_dq
);

   nfsp_cyc_e st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;
   logic wr_reg, wr_next;
   logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
   logic [P_AW-1:0] addr_reg, addr_next;
   logic [7:0] dq_reg, dq_next, rd_reg, rd_next;
   logic oe_reg, oe_next, done_reg, done_next;
   logic [7:0] s1_reg, s2_reg;

   // Two-stage synchroniser on the data pins
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
      end else if (i_en) begin
         s1_reg <= i_dq;
         s2_reg <= s1_reg;
      end
   end

   // Cycle sequencing; strobes stay low for whole clocks, far above glitch width
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      wr_next = wr_reg;
      ce_n_next = ce_n_reg;
      oe_n_next = oe_n_reg;
      we_n_next = we_n_reg;
      addr_next = addr_reg;
      dq_next = dq_reg;
      rd_next = rd_reg;
      oe_next = oe_reg;
      done_next = 1'b0;
      unique case (st_reg)
         CY_IDLE: begin
            if (i_go) begin
               st_next = CY_ACT;
               wr_next = i_write;
               addr_next = i_addr;
               dq_next = i_wdata;
               ce_n_next = 1'b0;
               oe_n_next = i_write;
               we_n_next = ~i_write;
               oe_next = i_write;
               cnt_next = i_write ? 8'(`NFSP_WR_CYC - 1) : 8'(`NFSP_RD_CYC + 1);
            end
         end
         CY_ACT: begin
            if (cnt_reg == 8'h00) begin
               st_next = CY_REC;
               ce_n_next = 1'b1;
               oe_n_next = 1'b1;
               we_n_next = 1'b1;
               if (!wr_reg) begin
                  rd_next = s2_reg;
               end
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         CY_REC: begin
            st_next = CY_IDLE;
            oe_next = 1'b0;
            done_next = 1'b1;
         end
      endcase
   end

   // Cycle registers
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_reg <= CY_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         ce_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         addr_reg <= '0;
         dq_reg <= 8'h00;
         rd_reg <= 8'h00;
         oe_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (i_en) begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         wr_reg <= wr_next;
         ce_n_reg <= ce_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         addr_reg <= addr_next;
         dq_reg <= dq_next;
         rd_reg <= rd_next;
         oe_reg <= oe_next;
         done_reg <= done_next;
      end
   end

   assign o_ce_n = ce_n_reg;
   assign o_oe_n = oe_n_reg;
   assign o_we_n = we_n_reg;
   assign o_addr = addr_reg;
   assign o_dq = dq_reg;
   assign o_dq_oe = oe_reg;
   assign o_done = done_reg;
   assign o_rdata = rd_reg;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || !i_en);

   dq_drive_a: assert property (o_dq_oe |-> o_oe_n)
      else $error("data driven while output enable low");
   idle_standby_a: assert property ((st_reg == CY_IDLE) |-> o_ce_n)
      else $error("chip select low between cycles");
   we_width_a: assert property ($fell(o_we_n) |-> !o_we_n [*3] ##1 o_we_n)
      else $error("write strobe width wrong");
   oe_width_a: assert property ($fell(o_oe_n) |-> !o_oe_n [*7] ##1 o_oe_n)
      else $error("read strobe width wrong");

endmodule
`default_nettype wire

// ==== nfsp_flash_mdl.sv ====
// Behavioural flash that answers the poller's status reads
`timescale 1ns/10ps
`default_nettype none
module nfsp_flash_mdl (
   // Flash pins
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_rst_n,
   input wire logic [22:0] i_addr,
   input wire logic [7:0] i_dq,
   // Flash data out
   output logic [7:0] o_dq
);
   int left = 0;
   int n_rd = 0;
   int n_wr = 0;
   logic err = 0;
   logic abt = 0;
   logic ers = 0;
   logic tog = 0;
   logic alt = 0;
   logic sus = 0;
   logic [6:0] blk = 7'h01;
   realtime t_we = 0;
   logic [7:0] val = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [22:0] wa = 23'h0;
   logic [7:0] lastd = 8'h00;
   logic [7:0] sts;
   logic [7:0] now;
   // Status byte while busy, array data when finished
   assign sts = {sus | (~ers & ~val[7]),
                 tog, err, 1'h0, ers,
                 ers & alt, abt, 1'h0};
   // Suspended erase: blocks other than the erasing one read array data
   assign now = (left > 0 && !(sus && i_addr[22:16] != blk)) ? sts : val;
   // Released lines show the inverse of the last byte
   assign o_dq = (!i_rst_n || i_ce_n || i_oe_n) ? ~lastd : now;
   // End of a read flips the toggle unless suspended, and counts down unless error or abort is set
   always @(posedge i_oe_n) begin
      if (i_rst_n) begin
         lastd = now;
         n_rd++;
         if (!sus)
            tog = ~tog;
         alt = ~alt;
         if (left > 0 && !err && !abt)
            left--;
      end
   end
   // Time of the falling write strobe, so that glitches are ignored
   always @(negedge i_we_n)
      t_we = $realtime;
   // A write records the command; read/reset ends the operation
   always @(posedge i_we_n) begin
      if (i_rst_n && $realtime - t_we >= 3.0) begin
         n_wr++;
         wd = i_dq;
         wa = i_addr;
         if (i_dq == 8'hF0) begin
            left = 0;
            err = 0;
            abt = 0;
         end
      end
   end
   // Hardware reset abandons the operation
   always @(negedge i_rst_n) begin
      left = 0;
   end
endmodule
`default_nettype wire

// ==== nfsp_pkg.sv ====
// Types shared by the status poller modules
`default_nettype none
package nfsp_pkg;

   // Main sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RST  = 7'h02,
      ST_RD1  = 7'h04,
      ST_RD2  = 7'h08,
      ST_EVAL = 7'h10,
      ST_CMD  = 7'h20,
      ST_HOLD = 7'h40
   } nfsp_state_e;

   // Single bus cycle states
   typedef enum logic [2:0] {
      CY_IDLE = 3'h1,
      CY_ACT  = 3'h2,
      CY_REC  = 3'h4
   } nfsp_cyc_e;

endpackage
`default_nettype wire

// ==== nfsp_regs.svh ====
// Offsets, field positions, command words and timing counts of the status poller
`ifndef NFSP_REGS_SVH
`define NFSP_REGS_SVH

// ********************************************************
// Clock and flash bus timing
// ********************************************************
`define NFSP_CLK_MHZ 50
`define NFSP_T_RD_NS 100
`define NFSP_T_WR_NS 60
`define NFSP_T_RP_NS 500
`define NFSP_RD_CYC ((`NFSP_T_RD_NS * `NFSP_CLK_MHZ + 999) / 1000)
`define NFSP_WR_CYC ((`NFSP_T_WR_NS * `NFSP_CLK_MHZ + 999) / 1000)
`define NFSP_RP_CYC ((`NFSP_T_RP_NS * `NFSP_CLK_MHZ + 999) / 1000)
`define NFSP_POLL_TMO 200000

// ********************************************************
// Register offsets
// ********************************************************
`define NFSP_OFF_CTRL 4'h0
`define NFSP_OFF_ADDR 4'h1
`define NFSP_OFF_DATA 4'h2
`define NFSP_OFF_STAT 4'h3
`define NFSP_OFF_LAST 4'h4

// ********************************************************
// Control and status fields
// ********************************************************
`define NFSP_CTRL_START 0
`define NFSP_CTRL_DPOLL 1
`define NFSP_CTRL_BLANK 2
`define NFSP_CTRL_HWRST 3
`define NFSP_CTRL_CLR 4
`define NFSP_ST_BUSY 0
`define NFSP_ST_DONE 1
`define NFSP_ST_FAIL 2
`define NFSP_ST_ABT 3
`define NFSP_ST_TMO 4
`define NFSP_ST_ALT 5
`define NFSP_ST_ETIM 6

// ********************************************************
// Flash status byte bits and command words
// ********************************************************
`define NFSP_POLL_BIT 7
`define NFSP_TOGGLE_BIT 6
`define NFSP_ERROR_BIT 5
`define NFSP_ETIMER_BIT 3
`define NFSP_ALT_BIT 2
`define NFSP_ABORT_BIT 1
`define NFSP_CMD_RESET 8'hF0
`define NFSP_CMD_UNL1 8'hAA
`define NFSP_CMD_UNL2 8'h55
`define NFSP_ADR_UNL1 12'h555
`define NFSP_ADR_UNL2 12'h2AA

`endif

// ==== nfsp_top.sv ====
// Host-side status poller for an asynchronous parallel NOR flash
`timescale 1ns/10ps
`default_nettype none
`include "nfsp_regs.svh"

// What this block does
// - After error, host issues read/reset first
// - Buffer abort needs abort-and-reset command sequence
// - Blank check tracked by toggle, not polling
// - Host polls at a valid operation address
module nfsp_top
   import nfsp_pkg::*;
#(
   parameter int P_AW = 23,
   parameter int P_TMO_CYC = `NFSP_POLL_TMO
) (
   // Clock, reset, enable
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_CLK_EN,
   // Register port
   input wire logic [3:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   output logic O_BUSY,
   // Flash pins
   output logic O_FL_CE_N,
   output logic O_FL_OE_N,
   output logic O_FL_WE_N,
   output logic O_FL_RST_N,
   output logic [P_AW-1:0] O_FL_ADDR,
   output logic [7:0] O_FL_DQ,
   output logic O_FL_DQ_OE,
   input wire logic [7:0] I_FL_DQ
);

   // ********************************************************
   // Helpers
   // ********************************************************

   // True when a bit differs between two successive status reads
   function automatic logic nfsp_flip(input logic [7:0] a, input logic [7:0] b,
                                      input int pos);
      return a[pos] ^ b[pos];
   endfunction

   nfsp_state_e st_reg, st_next;
   logic pend_reg, pend_next, go_reg, go_next, cwr_reg, cwr_next;
   logic [P_AW-1:0] caddr_reg, caddr_next, paddr_reg, paddr_next;
   logic [7:0] cwd_reg, cwd_next, a_reg, a_next, b_reg, b_next;
   logic [7:0] exp_reg, exp_next;
   logic [1:0] step_reg, step_next;
   logic chk_reg, chk_next, abc_reg, abc_next, dpoll_reg, dpoll_next;
   logic blank_reg, blank_next, flrst_n_reg, flrst_n_next, busy_reg, busy_next;
   logic [31:0] tmo_reg, tmo_next;
   logic [7:0] rcnt_reg, rcnt_next;
   logic done_reg, done_next, fail_reg, fail_next, abt_reg, abt_next;
   logic tmof_reg, tmof_next;
   logic [31:0] rdata_reg, rdata_next;
   logic set_done, set_fail, set_abt, set_tmo, ok, errs;
   logic wr_ctrl, clr;
   logic c_done;
   logic [7:0] c_rdata;

   assign wr_ctrl = I_WR && (I_ADDR == `NFSP_OFF_CTRL);
   assign clr = wr_ctrl && I_WDATA[`NFSP_CTRL_CLR];

   // ********************************************************
   // Poll sequencer
   // ********************************************************

   // Next-state logic of the poll sequencer
   always_comb begin
      st_next = st_reg;
      pend_next = pend_reg;
      go_next = 1'b0;
      cwr_next = cwr_reg;
      caddr_next = caddr_reg;
      cwd_next = cwd_reg;
      step_next = step_reg;
      a_next = a_reg;
      b_next = b_reg;
      chk_next = chk_reg;
      abc_next = abc_reg;
      dpoll_next = dpoll_reg;
      blank_next = blank_reg;
      flrst_n_next = flrst_n_reg;
      rcnt_next = rcnt_reg;
      tmo_next = tmo_reg;
      set_done = 1'b0;
      set_fail = 1'b0;
      set_abt = 1'b0;
      set_tmo = 1'b0;
      ok = dpoll_reg ? (b_reg[`NFSP_POLL_BIT] == exp_reg[`NFSP_POLL_BIT])
                     : !nfsp_flip(a_reg, b_reg, `NFSP_TOGGLE_BIT);
      errs = b_reg[`NFSP_ERROR_BIT] | b_reg[`NFSP_ABORT_BIT];
      unique case (st_reg)
         ST_IDLE: begin
            if (wr_ctrl && I_WDATA[`NFSP_CTRL_HWRST]) begin
               st_next = ST_RST;
               flrst_n_next = 1'b0;
               rcnt_next = 8'(`NFSP_RP_CYC - 1);
            end else if (wr_ctrl && I_WDATA[`NFSP_CTRL_START]) begin
               blank_next = I_WDATA[`NFSP_CTRL_BLANK];
               dpoll_next = I_WDATA[`NFSP_CTRL_DPOLL] & ~I_WDATA[`NFSP_CTRL_BLANK];
               chk_next = 1'b0;
               tmo_next = 32'h0000_0000;
               cwr_next = 1'b0;
               caddr_next = paddr_reg;
               st_next = (I_WDATA[`NFSP_CTRL_DPOLL] & ~I_WDATA[`NFSP_CTRL_BLANK])
                         ? ST_RD2 : ST_RD1;
            end
         end
         ST_RST: begin
            if (rcnt_reg == 8'h00) begin
               flrst_n_next = 1'b1;
               st_next = ST_HOLD;
            end else begin
               rcnt_next = rcnt_reg - 8'h01;
            end
         end
         ST_HOLD: begin
            st_next = ST_IDLE;
            set_done = 1'b1;
         end
         ST_RD1, ST_RD2: begin
            tmo_next = tmo_reg + 32'h0000_0001;
            if (!pend_reg) begin
               go_next = 1'b1;
               pend_next = 1'b1;
            end else if (c_done) begin
               pend_next = 1'b0;
               if (st_reg == ST_RD1) begin
                  a_next = c_rdata;
                  st_next = ST_RD2;
               end else begin
                  b_next = c_rdata;
                  st_next = ST_EVAL;
               end
            end
         end
         ST_EVAL: begin
            tmo_next = tmo_reg + 32'h0000_0001;
            if (ok) begin
               st_next = ST_IDLE;
               set_done = 1'b1;
            end else if (chk_reg || tmo_reg >= 32'(P_TMO_CYC)) begin
               set_fail = 1'b1;
               set_tmo = !chk_reg;
               abc_next = chk_reg & b_reg[`NFSP_ABORT_BIT];
               set_abt = chk_reg & b_reg[`NFSP_ABORT_BIT];
               step_next = 2'd0;
               cwr_next = 1'b1;
               st_next = ST_CMD;
            end else begin
               chk_next = errs;
               st_next = dpoll_reg ? ST_RD2 : ST_RD1;
            end
         end
         ST_CMD: begin
            if (!pend_reg) begin
               go_next = 1'b1;
               pend_next = 1'b1;
               if (!abc_reg || step_reg == 2'd2) begin
                  cwd_next = `NFSP_CMD_RESET;
                  caddr_next = P_AW'(`NFSP_ADR_UNL1);
               end else begin
                  cwd_next = (step_reg == 2'd0) ? `NFSP_CMD_UNL1 : `NFSP_CMD_UNL2;
                  caddr_next = (step_reg == 2'd0) ? P_AW'(`NFSP_ADR_UNL1)
                                                  : P_AW'(`NFSP_ADR_UNL2);
               end
            end else if (c_done) begin
               pend_next = 1'b0;
               if (!abc_reg || step_reg == 2'd2) begin
                  st_next = ST_IDLE;
                  cwr_next = 1'b0;
               end else begin
                  step_next = step_reg + 2'd1;
               end
            end
         end
      endcase
      busy_next = (st_next != ST_IDLE);
   end

   // Poll sequencer registers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_reg <= ST_IDLE;
         pend_reg <= 1'b0;
         go_reg <= 1'b0;
         cwr_reg <= 1'b0;
         caddr_reg <= '0;
         cwd_reg <= 8'h00;
         step_reg <= 2'd0;
         a_reg <= 8'h00;
         b_reg <= 8'h00;
         chk_reg <= 1'b0;
         abc_reg <= 1'b0;
         dpoll_reg <= 1'b0;
         blank_reg <= 1'b0;
         flrst_n_reg <= 1'b1;
         rcnt_reg <= 8'h00;
         tmo_reg <= 32'h0000_0000;
         busy_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         st_reg <= st_next;
         pend_reg <= pend_next;
         go_reg <= go_next;
         cwr_reg <= cwr_next;
         caddr_reg <= caddr_next;
         cwd_reg <= cwd_next;
         step_reg <= step_next;
         a_reg <= a_next;
         b_reg <= b_next;
         chk_reg <= chk_next;
         abc_reg <= abc_next;
         dpoll_reg <= dpoll_next;
         blank_reg <= blank_next;
         flrst_n_reg <= flrst_n_next;
         rcnt_reg <= rcnt_next;
         tmo_reg <= tmo_next;
         busy_reg <= busy_next;
      end
   end

   // ********************************************************
   // Register file
   // ********************************************************

   // Register writes, sticky flags (set beats clear) and read data
   always_comb begin
      paddr_next = paddr_reg;
      exp_next = exp_reg;
      if (I_WR && I_ADDR == `NFSP_OFF_ADDR) begin
         paddr_next = I_WDATA[P_AW-1:0];
      end
      if (I_WR && I_ADDR == `NFSP_OFF_DATA) begin
         exp_next = I_WDATA[7:0];
      end
      done_next = set_done | (done_reg & ~clr);
      fail_next = set_fail | (fail_reg & ~clr);
      abt_next = set_abt | (abt_reg & ~clr);
      tmof_next = set_tmo | (tmof_reg & ~clr);
      rdata_next = 32'h0000_0000;
      if (I_RD) begin
         case (I_ADDR)
            `NFSP_OFF_CTRL: rdata_next = {29'h0, blank_reg, dpoll_reg, 1'b0};
            `NFSP_OFF_ADDR: rdata_next = 32'(paddr_reg);
            `NFSP_OFF_DATA: rdata_next = {24'h0, exp_reg};
            `NFSP_OFF_STAT: rdata_next = {25'h0, b_reg[`NFSP_ETIMER_BIT],
                                          nfsp_flip(a_reg, b_reg, `NFSP_ALT_BIT),
                                          tmof_reg, abt_reg, fail_reg, done_reg, busy_reg};
            `NFSP_OFF_LAST: rdata_next = {16'h0, a_reg, b_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Register file registers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         paddr_reg <= '0;
         exp_reg <= 8'h00;
         done_reg <= 1'b0;
         fail_reg <= 1'b0;
         abt_reg <= 1'b0;
         tmof_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else if (I_CLK_EN) begin
         paddr_reg <= paddr_next;
         exp_reg <= exp_next;
         done_reg <= done_next;
         fail_reg <= fail_next;
         abt_reg <= abt_next;
         tmof_reg <= tmof_next;
         rdata_reg <= rdata_next;
      end
   end

   // ********************************************************
   // Flash bus cycle engine
   // ********************************************************
   nfsp_cyc #(.P_AW(P_AW)) u_cyc (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_en(I_CLK_EN),
      .i_go(go_reg),
      .i_write(cwr_reg),
      .i_addr(caddr_reg),
      .i_wdata(cwd_reg),
      .o_done(c_done),
      .o_rdata(c_rdata),
      .o_ce_n(O_FL_CE_N),
      .o_oe_n(O_FL_OE_N),
      .o_we_n(O_FL_WE_N),
      .o_addr(O_FL_ADDR),
      .o_dq(O_FL_DQ),
      .o_dq_oe(O_FL_DQ_OE),
      .i_dq(I_FL_DQ)
   );

   assign O_RDATA = rdata_reg;
   assign O_BUSY = busy_reg;
   assign O_FL_RST_N = flrst_n_reg;

   // ********************************************************
   // Checks
   // ********************************************************
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST || !I_CLK_EN);

   err_reset_a: assert property ((st_reg == ST_CMD && go_reg && !abc_reg) |->
      cwd_reg == `NFSP_CMD_RESET && cwr_reg)
      else $error("error recovery not a reset write");
   abort_seq_a: assert property ((st_reg == ST_CMD && go_reg && abc_reg &&
      step_reg == 2'd0) |-> cwd_reg == `NFSP_CMD_UNL1 ##[1:20]
      (go_reg && cwd_reg == `NFSP_CMD_UNL2))
      else $error("abort reset sequence wrong");
   blank_mode_a: assert property ((st_reg != ST_IDLE && blank_reg) |-> !dpoll_reg)
      else $error("blank check polled by polling bit");
   poll_addr_a: assert property ((go_reg && !cwr_reg) |-> caddr_reg == paddr_reg)
      else $error("status read at wrong address");
   toggle_done_a: assert property ((st_reg == ST_EVAL && !dpoll_reg &&
      !nfsp_flip(a_reg, b_reg, `NFSP_TOGGLE_BIT)) |=> st_reg == ST_IDLE && done_reg)
      else $error("steady toggle did not finish poll");
   reset_quiet_a: assert property ((st_reg == ST_RST) |-> !O_FL_RST_N && O_FL_CE_N)
      else $error("bus active during flash reset");

   cover_done_c: cover property (st_reg == ST_EVAL ##1 done_reg && !fail_reg);
   cover_abort_c: cover property (set_abt ##[1:100] st_reg == ST_IDLE);
   cover_hwrst_c: cover property (st_reg == ST_RST ##[1:40] st_reg == ST_IDLE);
   cover_tmo_c: cover property (set_tmo);

endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the flash status poller
`timescale 1ns/10ps
`default_nettype none
`include "nfsp_regs.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %h seen %h", n, e, s); end end
module tb_top;
   logic clk = 0;
   logic rst = 1;
   logic wr = 0;
   logic rd = 0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, d, st, ls;
   logic busy, ce_n, oe_n, we_n, rst_n, dq_oe;
   logic [22:0] fa;
   logic [7:0] dq_h, dq_f, dq_w;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int nw, n, nr;
   // Shared data wire
   assign dq_w = dq_oe ? dq_h : dq_f;
   // Clock
   always #10 clk = ~clk;
   // Run limit
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         end_of_test();
      end
   end
   nfsp_top #(.P_TMO_CYC(200)) dut_u (.I_CLK(clk), .I_RST(rst), .I_CLK_EN(1'h1),
      .I_ADDR(adr), .I_WDATA(wdat), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .O_BUSY(busy),
      .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n), .O_FL_RST_N(rst_n),
      .O_FL_ADDR(fa), .O_FL_DQ(dq_h), .O_FL_DQ_OE(dq_oe), .I_FL_DQ(dq_w));
   nfsp_flash_mdl mdl_u (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(rst_n),
      .i_addr(fa), .i_dq(dq_w), .o_dq(dq_f));
   // Register port accesses
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      adr <= a;
      wdat <= v;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      adr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdat;
   endtask
   // Set up the flash, start a poll, wait for idle, fetch results
   task automatic op(input int l, input logic e, a, s, input logic [31:0] c);
      mdl_u.left = l;
      mdl_u.err = e;
      mdl_u.abt = a;
      mdl_u.ers = s;
      mdl_u.tog = 1'h0;
      mdl_u.alt = 1'h0;
      nw = mdl_u.n_wr;
      wr_reg(`NFSP_OFF_CTRL, c);
      #1;
      for (int k = 0; k < 8 && busy !== 1'h1; k++) @(posedge clk) #1;
      for (int k = 0; k < 3000 && busy !== 1'h0; k++) @(posedge clk) #1;
      `CHK("idle", 1'h0, busy)
      nw = mdl_u.n_wr - nw;
      rd_reg(`NFSP_OFF_STAT);
      st = d;
      rd_reg(`NFSP_OFF_LAST);
      ls = d;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk) #1;
      `CHK("pins", 5'h1E, {ce_n, oe_n, we_n, rst_n, dq_oe})
      rd_reg(`NFSP_OFF_STAT);
      `CHK("stat0", 32'h0, d)
      rd_reg(4'h5);
      `CHK("unmapped", 32'h0, d)
      mdl_u.val = 8'hA1;
      wr_reg(`NFSP_OFF_ADDR, 32'h12345);
      wr_reg(`NFSP_OFF_DATA, 32'hA1);
      rd_reg(`NFSP_OFF_ADDR);
      `CHK("addr", 32'h12345, d)
      op(2, 0, 0, 0, 32'h11);
      `CHK("tog st", 32'h2, st)
      `CHK("tog last", 32'hA1A1, ls)
      `CHK("tog addr", 23'h12345, fa)
      `CHK("tog wr", 0, nw)
      op(2, 0, 0, 0, 32'h13);
      `CHK("dp st", 5'h02, st[4:0])
      `CHK("dp last", 8'hA1, ls[7:0])
      op(1000, 1, 0, 0, 32'h11);
      `CHK("err st", 2'h1, st[3:2])
      `CHK("err wr", 1, nw)
      `CHK("err cmd", 8'hF0, mdl_u.wd)
      `CHK("err adr", 23'h555, mdl_u.wa)
      op(1000, 0, 1, 0, 32'h11);
      `CHK("abt st", 1'h1, st[3])
      `CHK("abt wr", 3, nw)
      `CHK("abt cmd", 8'hF0, mdl_u.wd)
      op(100000, 0, 0, 1, 32'h11);
      `CHK("ers st", 4'hF, {st[6:4], st[2]})
      `CHK("ers last", 2'h1, {ls[7], ls[3]})
      `CHK("ers wr", 1, nw)
      mdl_u.sus = 1'h1;
      op(100000, 0, 0, 1, 32'h11);
      `CHK("sus st", 32'h62, st)
      `CHK("sus last", 32'h888C, ls)
      wr_reg(`NFSP_OFF_ADDR, 32'h345);
      op(100000, 0, 0, 1, 32'h13);
      `CHK("sus blk", 8'hA1, ls[7:0])
      mdl_u.sus = 1'h0;
      op(2, 0, 0, 1, 32'h17);
      `CHK("blank last", 16'hA1A1, ls[15:0])
      rd_reg(`NFSP_OFF_CTRL);
      `CHK("ctrl rb", 2'h2, d[2:1])
      nr = mdl_u.n_rd;
      n = 0;
      wr_reg(`NFSP_OFF_CTRL, 32'h19);
      repeat (60) begin
         #1;
         if (rst_n === 1'h0)
            n++;
         @(posedge clk);
      end
      `CHK("rst len", 25, n)
      `CHK("rst prio", nr, mdl_u.n_rd)
      rd_reg(`NFSP_OFF_STAT);
      `CHK("rst done", 1'h1, d[1])
      wr_reg(`NFSP_OFF_CTRL, 32'h10);
      rd_reg(`NFSP_OFF_STAT);
      `CHK("clr", 5'h0, d[4:0])
      end_of_test();
   end
endmodule
`default_nettype wire
